// >>> ecp_pkg.sv
// Package for the event capture and auxiliary PWM block
package ecp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_COUNTER  = 8'h00;
  localparam logic [7:0] OFF_PHASE    = 8'h04;
  localparam logic [7:0] OFF_CAPTURE_REG_ONE     = 8'h08;
  localparam logic [7:0] OFF_CAPTURE_REG_TWO     = 8'h0C;
  localparam logic [7:0] OFF_CAPTURE_REG_THREE     = 8'h10;
  localparam logic [7:0] OFF_CAPTURE_REG_FOUR     = 8'h14;
  localparam logic [7:0] OFF_CTL_ONE  = 8'h18;
  localparam logic [7:0] OFF_CTL_TWO  = 8'h1C;
  localparam logic [7:0] OFF_INT_EN   = 8'h20;
  localparam logic [7:0] OFF_INT_FLAG = 8'h24;
  localparam logic [7:0] OFF_INT_CLR  = 8'h28;
  localparam logic [7:0] OFF_INT_FRC  = 8'h2C;
  localparam int         ADDR_W       = 8;

  // Control one field positions
  localparam int CTL1_POL0    = 0;  // Polarity of event k at 2k
  localparam int CTL1_RST0    = 1;  // Counter reset of event k at 2k+1
  localparam int CTL1_LDEN    = 8;
  localparam int CTL1_PS_LO   = 9;
  localparam int CTL1_PS_HI   = 13;
  localparam logic [15:0] CTL1_MASK = 16'h3FFF;

  // Control two field positions
  localparam int CTL2_CONT    = 0;
  localparam int CTL2_STOP_LO = 1;
  localparam int CTL2_STOP_HI = 2;
  localparam int CTL2_REARM   = 3;  // Write-one pulse, reads zero
  localparam int CTL2_SYNC_EN = 5;
  localparam int CTL2_SWSYNC  = 8;  // Write-one pulse, reads zero
  localparam int CTL2_MODE    = 9;
  localparam int CTL2_PWMPOL  = 10;
  localparam logic [15:0] CTL2_MASK = 16'h0627;

  // Interrupt flag positions
  localparam int FLG_GLOBAL = 0;
  localparam int FLG_CEVT0  = 1;  // Four capture events at 1..4
  localparam int FLG_OVF    = 5;
  localparam int FLG_PRD    = 6;
  localparam int FLG_CMP    = 7;
  localparam logic [7:0] EVT_MASK = 8'hFE;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef struct packed {
    logic       cont;
    logic [1:0] stop_value;
    logic       sync_en;
    logic       mode_pwm;
    logic       pwm_pol;
  } ecp_ctl_s;
endpackage

// >>> ecp_core.sv
// Event capture unit with auxiliary PWM and AXI4-Lite registers
// Notes on behaviour
// - Capture input is divided by an even factor 2 to 62 before qualification.
// - Prescale select of zero bypasses the divider entirely.
// - Each of four events picks rising or falling edge independently.
// - Qualified edge loads only the capture register chosen by the sequencer.
// - Two-bit sequencer advances on each qualified event and wraps 3 to 0.
// - One-shot: sequencer equal to stop value freezes sequencer and loads.
// - Re-arm clears sequencer and allows loads if load enable is set.
// - Continuous mode ignores the stop value and fills a circular buffer.
// - A 32-bit counter clocked by the system clock is the time stamp.
// - Sync input or software sync loads the phase value into the counter.
// - Per-event optional counter reset clears counter after the capture.
// - Cleared load enable blocks loads; one-shot stop clears it.
// - Counter wrap from all ones to zero raises an overflow event.
// - Seven events have enables, latched flags, global flag and force.
// - Interrupt pulse only when an enabled flag is set and global is clear.
// - Capture flags only in capture mode, match flags only in PWM mode.
// - PWM mode loads shadows into period and compare only at period match; capture blocks.
// - In PWM mode writing active period or compare also writes its shadow.
// - PWM mode counts up, registers one/two are period/compare, pin drives.
// - Compare zero low, n gives n high cycles, above period high; invert.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
module ecp_core (
  input  wire logic        sys_clk,        // System clock, 200 MHz
  input  wire logic        rst,            // Synchronous reset, active high
  input  wire logic        sync_in,        // Hardware sync pulse
  input  wire logic        cap_pin_i,      // Shared pin input level
  output logic             cap_pin_o,      // Shared pin output level
  output logic             cap_pin_oe,     // Shared pin drive enable
  output logic             int_pulse,      // Interrupt pulse
  input  wire logic [7:0]  s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [7:0]  s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready    // Read data ready
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]          counter_reg;
  logic [31:0]          phase_reg;
  logic [31:0]          cap_reg [4];
  logic [15:0]          ctl_one_reg;
  ecp_pkg::ecp_ctl_s    ctl_reg;
  logic [7:0]           int_enable_reg;
  logic [7:0]           int_flag_reg;
  logic [1:0]           event_sequencer;
  logic                 pin_d_reg;
  logic                 ps_level_reg;
  logic [5:0]           ps_count_reg;
  logic [4:0]           ps_sel;
  logic                 prescaled_event_out;
  logic                 ps_prev_reg;
  logic                 rise;
  logic                 fall;
  logic                 edge_hit;
  logic                 capture_load_enable;
  logic [3:0]           capture_load_strobes;
  logic                 load_ok;
  logic                 cnt_clear;
  logic                 counter_overflow_event;
  logic                 period_match_event;
  logic                 compare_match_event;
  logic                 pwm_level;
  logic                 aw_held_reg;
  logic                 w_held_reg;
  logic [7:0]           aw_addr_reg;
  logic [31:0]          w_data_reg;
  logic [3:0]           w_strb_reg;
  logic                 wr_fire;
  logic [31:0]          wr_mask;
  logic                 wr_hit;
  logic                 rd_fire;
  logic [31:0]          rd_val;
  logic                 rd_hit;
  logic                 sw_rearm;
  logic                 sw_sync;
  logic [7:0]           clr_bits;
  logic [7:0]           frc_bits;
  logic [7:0]           evt_raw;
  logic                 armed_reg;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] o);
    addr_is = (a == o);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ecp_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? ecp_pkg::AXI_OKAY : ecp_pkg::AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_mask[8*b +: 8] = {8{w_strb_reg[b]}};
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    if (addr_is(aw_addr_reg, ecp_pkg::OFF_COUNTER)) wr_hit = 1'b1;
    else if (addr_is(aw_addr_reg, ecp_pkg::OFF_PHASE)) wr_hit = 1'b1;
    else if (aw_addr_reg >= ecp_pkg::OFF_CAPTURE_REG_ONE &&
             aw_addr_reg <= ecp_pkg::OFF_INT_FRC &&
             aw_addr_reg[1:0] == 2'h0) wr_hit = 1'b1;
    else wr_hit = 1'b0;
  end

  // One-cycle command pulses from write-only bits
  assign sw_rearm = wr_fire && addr_is(aw_addr_reg, ecp_pkg::OFF_CTL_TWO)
                    && w_strb_reg[0] && w_data_reg[ecp_pkg::CTL2_REARM];
  assign sw_sync  = wr_fire && addr_is(aw_addr_reg, ecp_pkg::OFF_CTL_TWO)
                    && w_strb_reg[1] && w_data_reg[ecp_pkg::CTL2_SWSYNC];
  assign clr_bits = (wr_fire && addr_is(aw_addr_reg, ecp_pkg::OFF_INT_CLR)
                     && w_strb_reg[0]) ? w_data_reg[7:0] : 8'h00;
  assign frc_bits = (wr_fire && addr_is(aw_addr_reg, ecp_pkg::OFF_INT_FRC)
                     && w_strb_reg[0]) ?
                    (w_data_reg[7:0] & ecp_pkg::EVT_MASK) : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read: one cycle latency
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (addr_is(s_axi_araddr, ecp_pkg::OFF_COUNTER)) rd_val = counter_reg;
    else if (addr_is(s_axi_araddr, ecp_pkg::OFF_PHASE)) rd_val = phase_reg;
    else if (addr_is(s_axi_araddr, ecp_pkg::OFF_CAPTURE_REG_ONE)) rd_val = cap_reg[0];
    else if (addr_is(s_axi_araddr, ecp_pkg::OFF_CAPTURE_REG_TWO)) rd_val = cap_reg[1];
    else if (addr_is(s_axi_araddr, ecp_pkg::OFF_CAPTURE_REG_THREE)) rd_val = cap_reg[2];
    else if (addr_is(s_axi_araddr, ecp_pkg::OFF_CAPTURE_REG_FOUR)) rd_val = cap_reg[3];
    else if (addr_is(s_axi_araddr, ecp_pkg::OFF_CTL_ONE))
      rd_val = {16'h0000, ctl_one_reg};
    else if (addr_is(s_axi_araddr, ecp_pkg::OFF_CTL_TWO))
      rd_val = {21'h000000, ctl_reg.pwm_pol, ctl_reg.mode_pwm, 3'h0,
                ctl_reg.sync_en, 2'h0, ctl_reg.stop_value, ctl_reg.cont};
    else if (addr_is(s_axi_araddr, ecp_pkg::OFF_INT_EN))
      rd_val = {24'h000000, int_enable_reg};
    else if (addr_is(s_axi_araddr, ecp_pkg::OFF_INT_FLAG))
      rd_val = {24'h000000, int_flag_reg};
    else if (addr_is(s_axi_araddr, ecp_pkg::OFF_INT_CLR)) rd_val = '0;
    else if (addr_is(s_axi_araddr, ecp_pkg::OFF_INT_FRC)) rd_val = '0;
    else rd_hit = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ecp_pkg::AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? ecp_pkg::AXI_OKAY : ecp_pkg::AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_one_reg    <= 16'h0000;
      ctl_reg        <= '0;
      int_enable_reg <= 8'h00;
      phase_reg      <= 32'h0000_0000;
    end else if (wr_fire) begin
      if (addr_is(aw_addr_reg, ecp_pkg::OFF_CTL_ONE))
        ctl_one_reg <= 16'(merge({16'h0000, ctl_one_reg}, w_data_reg,
                             wr_mask)) & ecp_pkg::CTL1_MASK;
      else if (addr_is(aw_addr_reg, ecp_pkg::OFF_CTL_TWO) && w_strb_reg[0]) begin
        ctl_reg.cont       <= w_data_reg[ecp_pkg::CTL2_CONT];
        ctl_reg.stop_value <=
          w_data_reg[ecp_pkg::CTL2_STOP_HI:ecp_pkg::CTL2_STOP_LO];
        ctl_reg.sync_en    <= w_data_reg[ecp_pkg::CTL2_SYNC_EN];
      end
      if (addr_is(aw_addr_reg, ecp_pkg::OFF_CTL_TWO) && w_strb_reg[1]) begin
        ctl_reg.mode_pwm <= w_data_reg[ecp_pkg::CTL2_MODE];
        ctl_reg.pwm_pol  <= w_data_reg[ecp_pkg::CTL2_PWMPOL];
      end
      if (addr_is(aw_addr_reg, ecp_pkg::OFF_INT_EN) && w_strb_reg[0])
        int_enable_reg <= w_data_reg[7:0] & ecp_pkg::EVT_MASK;
      if (addr_is(aw_addr_reg, ecp_pkg::OFF_PHASE))
        phase_reg <= merge(phase_reg, w_data_reg, wr_mask);
    end
    if (!rst && load_ok && armed_reg && !ctl_reg.cont &&
        event_sequencer == ctl_reg.stop_value)
      ctl_one_reg[ecp_pkg::CTL1_LDEN] <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event prescaler and edge qualifier
  assign ps_sel = ctl_one_reg[ecp_pkg::CTL1_PS_HI:ecp_pkg::CTL1_PS_LO];

  // Toggle output every ps_sel input rising edges gives divide by 2*ps_sel
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_d_reg    <= 1'b0;
      ps_level_reg <= 1'b0;
      ps_count_reg <= 6'h00;
    end else begin
      pin_d_reg <= cap_pin_i;
      if (ps_sel == 5'h00 || ctl_reg.mode_pwm) begin
        ps_count_reg <= 6'h00;
        ps_level_reg <= 1'b0;
      end else if (cap_pin_i && !pin_d_reg) begin
        if (ps_count_reg + 6'h01 >= {1'b0, ps_sel}) begin
          ps_count_reg <= 6'h00;
          ps_level_reg <= !ps_level_reg;
        end else begin
          ps_count_reg <= ps_count_reg + 6'h01;
        end
      end
    end
  end

  assign prescaled_event_out = (ps_sel == 5'h00) ? cap_pin_i
                                                 : ps_level_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) ps_prev_reg <= 1'b0;
    else     ps_prev_reg <= prescaled_event_out;
  end

  assign rise = prescaled_event_out && !ps_prev_reg;
  assign fall = !prescaled_event_out && ps_prev_reg;
  // Polarity bit 1 selects falling edge for the current event
  assign edge_hit = !ctl_reg.mode_pwm &&
    (ctl_one_reg[ecp_pkg::CTL1_POL0 + 2*event_sequencer] ? fall : rise);
  assign capture_load_enable = ctl_one_reg[ecp_pkg::CTL1_LDEN];
  assign load_ok = edge_hit && capture_load_enable;

  generate
    for (genvar k = 0; k < 4; k++) begin : g_ld
      assign capture_load_strobes[k] =
        load_ok && (event_sequencer == 2'(k));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer with one-shot stop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      event_sequencer <= 2'h0;
      armed_reg       <= 1'b1;
    end else if (sw_rearm) begin
      event_sequencer <= 2'h0;
      armed_reg       <= 1'b1;
    end else if (load_ok && (armed_reg || ctl_reg.cont)) begin
      if (!ctl_reg.cont && event_sequencer == ctl_reg.stop_value)
        armed_reg <= 1'b0;
      else
        event_sequencer <= event_sequencer + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base counter
  assign cnt_clear = |(capture_load_strobes & {ctl_one_reg[7],
    ctl_one_reg[5], ctl_one_reg[3], ctl_one_reg[ecp_pkg::CTL1_RST0]});
  assign counter_overflow_event = (counter_reg == 32'hFFFF_FFFF);
  assign period_match_event = ctl_reg.mode_pwm && (counter_reg == cap_reg[0]);
  assign compare_match_event = ctl_reg.mode_pwm && (counter_reg == cap_reg[1]);

  always_ff @(posedge sys_clk) begin
    if (rst)
      counter_reg <= 32'h0000_0000;
    else if ((ctl_reg.sync_en && sync_in) || sw_sync)
      counter_reg <= phase_reg;
    else if (wr_fire && addr_is(aw_addr_reg, ecp_pkg::OFF_COUNTER))
      counter_reg <= merge(counter_reg, w_data_reg, wr_mask);
    else if (cnt_clear && armed_reg || cnt_clear && ctl_reg.cont)
      counter_reg <= 32'h0000_0000;
    else if (period_match_event)
      counter_reg <= 32'h0000_0000;
    else
      counter_reg <= counter_reg + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture and shadow registers
  generate
    for (genvar k = 0; k < 4; k++) begin : g_cap
      logic sw_wr;
      logic act_wr;
      assign sw_wr = wr_fire && addr_is(aw_addr_reg,
                       ecp_pkg::OFF_CAPTURE_REG_ONE + 8'(4*k));
      // In PWM mode, writes to active registers one/two are mirrored into the shadows
      assign act_wr = (k >= 2) && ctl_reg.mode_pwm && wr_fire &&
        addr_is(aw_addr_reg, ecp_pkg::OFF_CAPTURE_REG_ONE + 8'(4*(k-2)));
      always_ff @(posedge sys_clk) begin
        if (rst)
          cap_reg[k] <= 32'h0000_0000;
        else if (sw_wr || act_wr)
          cap_reg[k] <= merge(cap_reg[k], w_data_reg, wr_mask);
        else if (k < 2 && period_match_event)
          cap_reg[k] <= cap_reg[(k+2)%4];
        else if (capture_load_strobes[k] && (armed_reg || ctl_reg.cont))
          cap_reg[k] <= counter_reg;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Load enable is cleared by the one-shot stop via the control register
  // Interrupt flags, force, clear and pulse
  always_comb begin
    evt_raw = 8'h00;
    for (int k = 0; k < 4; k++)
      evt_raw[ecp_pkg::FLG_CEVT0 + k] = capture_load_strobes[k] &&
        (armed_reg || ctl_reg.cont) && !ctl_reg.mode_pwm;
    evt_raw[ecp_pkg::FLG_OVF] = counter_overflow_event;
    evt_raw[ecp_pkg::FLG_PRD] = period_match_event;
    evt_raw[ecp_pkg::FLG_CMP] = compare_match_event;
  end

  logic int_fire;
  assign int_fire = |(int_flag_reg & int_enable_reg & ecp_pkg::EVT_MASK)
                    && !int_flag_reg[ecp_pkg::FLG_GLOBAL];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      int_flag_reg <= 8'h00;
      int_pulse    <= 1'b0;
    end else begin
      // Set wins over clear for every bit
      int_flag_reg <= (int_flag_reg & ~clr_bits) | evt_raw | frc_bits
                      | {7'h00, int_fire};
      int_pulse <= int_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM output: high while counter below compare, inverted when pwm_pol is set
  assign pwm_level = (counter_reg < cap_reg[1]);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cap_pin_o  <= 1'b0;
      cap_pin_oe <= 1'b0;
    end else begin
      cap_pin_oe <= ctl_reg.mode_pwm;
      cap_pin_o  <= ctl_reg.mode_pwm && (pwm_level ^ ctl_reg.pwm_pol);
    end
  end
endmodule

// >>> ecp_core_props.sv
// Checker on the ports of the event capture block
module ecp_core_props (
  input wire logic        sys_clk,       // Clock
  input wire logic        rst,           // Reset
  input wire logic        cap_pin_oe,    // Pin drive enable
  input wire logic        int_pulse,     // Interrupt pulse
  input wire logic        s_axi_awready, // AW ready
  input wire logic        s_axi_wvalid,  // W valid
  input wire logic        s_axi_wready,  // W ready
  input wire logic [1:0]  s_axi_bresp,   // B response
  input wire logic        s_axi_bvalid,  // B valid
  input wire logic        s_axi_bready,  // B ready
  input wire logic        s_axi_arvalid, // AR valid
  input wire logic        s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata,   // R data
  input wire logic        s_axi_rvalid,  // R valid
  input wire logic        s_axi_rready   // R ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  property p_rst_quiet;
    $fell(rst) |-> !int_pulse && !cap_pin_oe && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("not quiet at reset");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_r_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_refuse: assert property (p_r_refuse) else $error("read taken while busy");
  property p_b_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("write taken while busy");
  property p_oe_cause;
    $rose(cap_pin_oe) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
      || $past(s_axi_wvalid, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive without write");
  property p_pulse_gap;
    int_pulse ##1 !s_axi_wvalid [*4] |-> !int_pulse;
  endproperty
  a_pulse_gap: assert property (p_pulse_gap) else $error("pulse not blocked");
  c_pulse: cover property (int_pulse);
  c_pwm: cover property ($rose(cap_pin_oe));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == ecp_pkg::AXI_SLVERR);
endmodule
bind ecp_core ecp_core_props u_props (.*);

// >>> ecp_pulse_src.sv
// Pulse train source standing on the capture pin
module ecp_pulse_src (
  input  wire logic       sys_clk,  // Clock
  input  wire logic       run,      // Train enable
  input  wire logic [7:0] half_cyc, // Cycles per half period
  output logic            pin       // Pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg;
  always_ff @(posedge sys_clk) begin
    if (!run) begin
      cnt_reg <= 8'h00;
      pin <= 1'b0;
    end else if (cnt_reg == half_cyc - 8'h01) begin
      cnt_reg <= 8'h00;
      pin <= ~pin;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

// >>> ecp_core_test.sv
// Self-checking bench for the event capture block
module ecp_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0, rst = 1'b1, sync_in = 1'b0, src_run = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, half_cyc = 8'h0A;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, c[4];
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, cap_pin_o, cap_pin_oe, int_pulse, src_pin;
  int          mismatches = 0, cmp_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  ecp_core uut (.*, .cap_pin_i(cap_pin_oe ? cap_pin_o : src_pin));
  ecp_pulse_src u_src (.sys_clk(sys_clk), .run(src_run), .half_cyc(half_cyc),
    .pin(src_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic fail_to(input string what);
    mismatches++;
    $display("mismatch at %0t: timeout in %s", $time, what);
    report_and_stop();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, dd, bd;
    int n;
    ad = 0;
    dd = 0;
    bd = 0;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bd) begin
      @(posedge sys_clk);
      if (++n > 60) fail_to("write");
      if (ad && dd && s_axi_bvalid === 1'b1) begin
        bd = 1;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready === 1'b1) begin
        dd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (++n > 60) fail_to("read");
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_int;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      if (++n > 400) fail_to("interrupt wait");
    end while (int_pulse !== 1'b1);
  endtask
  task automatic read_caps;
    src_run <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      rdr(ecp_pkg::OFF_CAPTURE_REG_ONE + 8'(4 * k));
      c[k] = rd;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_bus;
    wr(8'h30, 32'h1);
    chk(32'(resp), 32'(ecp_pkg::AXI_SLVERR), "unmapped write");
    rdr(8'h30);
    chk(32'(resp), 32'(ecp_pkg::AXI_SLVERR), "unmapped read");
    rdr(ecp_pkg::OFF_INT_CLR);
    chk(rd, 32'h0, "clear reads zero");
    $display("test bus done");
  endtask
  task automatic t_oneshot;
    wr(ecp_pkg::OFF_INT_EN, 32'h02);
    for (int k = 0; k < 2; k++) begin
      wr(ecp_pkg::OFF_CTL_ONE, 32'h104);
      wr(ecp_pkg::OFF_INT_CLR, 32'hFF);
      wr(ecp_pkg::OFF_CTL_TWO, 32'h00A);
      src_run <= 1'b1;
      wait_int();
      repeat (100) @(posedge sys_clk);
      read_caps();
      chk(c[1] - c[0], 32'hA, "rise to fall");
      chk(c[2], 32'h0, "frozen after stop");
      rdr(ecp_pkg::OFF_CTL_ONE);
      chk(rd, 32'h004, "load enable cleared");
      rdr(ecp_pkg::OFF_INT_FLAG);
      chk(rd & 32'hFF, 32'h07, "flags after one-shot");
    end
    $display("test one-shot done");
  endtask
  task automatic t_prescale;
    int n40;
    int ps[2] = '{1, 31};
    for (int k = 0; k < 2; k++) begin
      wr(ecp_pkg::OFF_CTL_ONE, 32'h100 | (ps[k] << 9));
      wr(ecp_pkg::OFF_CTL_TWO, 32'h009);
      src_run <= 1'b1;
      repeat (240 * ps[k]) @(posedge sys_clk);
      read_caps();
      n40 = 0;
      for (int j = 0; j < 4; j++) n40 += (c[(j + 1) % 4] - c[j] == 40 * ps[k]);
      chk(n40, 32'h3, "prescaled ring spacing");
    end
    $display("test prescale done");
  endtask
  task automatic t_sync;
    wr(ecp_pkg::OFF_PHASE, 32'h100);
    wr(ecp_pkg::OFF_CTL_TWO, 32'h100);
    rdr(ecp_pkg::OFF_COUNTER);
    chk(32'(rd - 32'h100 < 32'h20), 32'h1, "soft sync");
    wr(ecp_pkg::OFF_PHASE, 32'h2000);
    wr(ecp_pkg::OFF_CTL_TWO, 32'h020);
    sync_in <= 1'b1;
    @(posedge sys_clk);
    sync_in <= 1'b0;
    rdr(ecp_pkg::OFF_COUNTER);
    chk(32'(rd - 32'h2000 < 32'h20), 32'h1, "hard sync");
    wr(ecp_pkg::OFF_INT_CLR, 32'hFF);
    wr(ecp_pkg::OFF_INT_EN, 32'h20);
    wr(ecp_pkg::OFF_PHASE, 32'hFFFFFFC0);
    wr(ecp_pkg::OFF_CTL_TWO, 32'h100);
    wait_int();
    rdr(ecp_pkg::OFF_INT_FLAG);
    chk(rd & 32'hFF, 32'h21, "overflow flag");
    wr(ecp_pkg::OFF_INT_CLR, 32'hFF);
    wr(ecp_pkg::OFF_INT_FRC, 32'h02);
    rdr(ecp_pkg::OFF_INT_FLAG);
    chk(rd & 32'hFF, 32'h02, "forced flag");
    wr(ecp_pkg::OFF_INT_CLR, 32'hFF);
    $display("test sync done");
  endtask
  task automatic t_pwm;
    int hi;
    int val[5] = '{0, 3, 10, 3, 5};
    int pol[5] = '{0, 0, 0, 1, 0};
    int exp[5] = '{0, 6, 20, 14, 10};
    wr(ecp_pkg::OFF_PHASE, 32'h0);
    wr(ecp_pkg::OFF_CTL_TWO, 32'h300);
    wr(ecp_pkg::OFF_CAPTURE_REG_ONE, 32'h9);
    wr(ecp_pkg::OFF_CAPTURE_REG_TWO, 32'h3);
    rdr(ecp_pkg::OFF_CAPTURE_REG_THREE);
    chk(rd, 32'h9, "period shadow");
    rdr(ecp_pkg::OFF_CAPTURE_REG_FOUR);
    chk(rd, 32'h3, "compare shadow");
    for (int k = 0; k < 5; k++) begin
      wr(ecp_pkg::OFF_CTL_TWO, 32'h200 | (pol[k] << 10));
      wr(k == 4 ? ecp_pkg::OFF_CAPTURE_REG_FOUR : ecp_pkg::OFF_CAPTURE_REG_TWO, val[k]);
      repeat (12) @(posedge sys_clk);
      hi = 0;
      repeat (20) begin
        @(posedge sys_clk);
        hi += (cap_pin_o === 1'b1);
      end
      chk(hi, exp[k], "high cycles");
      chk(32'(cap_pin_oe), 32'h1, "pin driven");
    end
    rdr(ecp_pkg::OFF_INT_FLAG);
    chk(rd & 32'h5E, 32'h40, "mode flags");
    $display("test pwm done");
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_bus();
    t_oneshot();
    t_prescale();
    t_sync();
    t_pwm();
    report_and_stop();
  end
endmodule
